// *** inc/fpd_cfg.svh ***
`ifndef FPD_CFG_SVH
`define FPD_CFG_SVH

// Register indices; each register is one APB word at four times its index
`define FPD_ADDR_W 10
`define FPD_IDX_PDC 8'hC5
`define FPD_IDX_CW 8'hC6
`define FPD_OFS_PDC 10'h314
`define FPD_OFS_CW 10'h318
`define FPD_REG_W 16
`define FPD_RST_PDC 16'h0000
`define FPD_RST_CW 16'h0000

// Power-down control field positions
`define FPD_B_DEEP 15
`define FPD_B_QUICK 14
`define FPD_B_PREAMP 13
`define FPD_B_ATTAMP 12
`define FPD_B_PROF_HI 11
`define FPD_B_PROF_LO 10
`define FPD_B_QUIET 9
`define FPD_B_PDC_RSV 8
`define FPD_B_PAIR_HI 7
`define FPD_B_PAIR_LO 0
`define FPD_PAIRS 8
`define FPD_CHANS 16

// Continuous-wave register reserved bits
`define FPD_B_CW_RSV_HI 15
`define FPD_B_CW_RSV_LO 7

`endif

// *** inc/fpd_pkg.sv ***
package fpd_pkg;
    typedef enum logic [1:0] {
        FPD_PROF_LOW_NOISE = 2'h0,
        FPD_PROF_LOW_POWER = 2'h1,
        FPD_PROF_MED_POWER = 2'h2,
        FPD_PROF_RESERVED = 2'h3
    } fpd_prof_e;

    typedef enum logic [2:0] {
        FPD_ST_IDLE = 3'h1,
        FPD_ST_SETUP = 3'h2,
        FPD_ST_ACCESS = 3'h4
    } fpd_state_e;

    typedef struct packed {
        fpd_state_e st;
        logic [15:0] pdc;
        logic [15:0] cw;
        logic [31:0] rdata;
        logic slverr;
    } fpd_state_s;

    typedef struct packed {
        logic [1:0] full_off;
        logic [1:0] quick_off;
        logic [1:0] preamp_off;
        logic [1:0] attenuator_amp_off;
        logic [1:0] quiet_input_option;
        logic [1:0] low_noise;
        logic [1:0] low_power;
        logic [1:0] med_power;
    } fpd_die_ctl_s;
endpackage : fpd_pkg

// *** rtl/fpd_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fpd_cfg.svh"

module fpd_decode (
    input wire logic [15:0] pdc,
    input wire logic die_offset,
    output fpd_pkg::fpd_die_ctl_s die_ctl,
    output logic [15:0] chan_off
);

    // Die 1 always follows; die 2 only when the offset is zero
    function automatic logic [1:0] fpd_spread(input logic en, input logic off);
        fpd_spread = {en & ~off, en};
    endfunction : fpd_spread

    logic [1:0] prof;

    always_comb begin
        prof = pdc[`FPD_B_PROF_HI:`FPD_B_PROF_LO];
        die_ctl.full_off = fpd_spread(pdc[`FPD_B_DEEP], die_offset);
        // Slow full power-down overrides the fast one
        die_ctl.quick_off = fpd_spread(pdc[`FPD_B_QUICK]
            & ~pdc[`FPD_B_DEEP], die_offset);
        die_ctl.preamp_off = fpd_spread(pdc[`FPD_B_PREAMP], die_offset);
        die_ctl.attenuator_amp_off =
            fpd_spread(pdc[`FPD_B_ATTAMP], die_offset);
        die_ctl.quiet_input_option =
            fpd_spread(pdc[`FPD_B_QUIET], die_offset);
        die_ctl.low_noise = fpd_spread(prof == fpd_pkg::FPD_PROF_LOW_NOISE,
            die_offset);
        die_ctl.low_power = fpd_spread(prof == fpd_pkg::FPD_PROF_LOW_POWER,
            die_offset);
        die_ctl.med_power = fpd_spread(prof == fpd_pkg::FPD_PROF_MED_POWER,
            die_offset);
        // Channel 2k+1 is the odd one (index 2k), 2k+2 the even one
        for (int k = 0; k < `FPD_PAIRS; k++) begin
            chan_off[2*k] = pdc[k] & ~die_offset;
            chan_off[2*k+1] = pdc[k];
        end
    end

endmodule : fpd_decode
`default_nettype wire

// *** rtl/fpd_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fpd_cfg.svh"

// What this block does
// - Deep sleep with offset zero fully powers down both gain dies.
// - Offset one confines every power-down control to the first die.
// - Deep sleep wins over quick sleep when both are set.
// - Deep and quick sleep never power down the converter channels.
// - Quick sleep partially powers down selected dies, keeping fast wake.
// - Preamp-off bit powers down only preamplifiers on selected dies.
// - Attenuator-amp bit powers down attenuator and gain stages on selected dies.
// - Profile 00 low-noise, 01 low-power, 10 medium-power, 11 reserved.
// - Profile applies to both dies, or first die only with offset one.
// - Quiet-input bit enables low-noise-figure mode on selected dies.
// - Pair bit k powers down channels 2k+1 and 2k+2.
// - With offset one a pair bit powers down only the even channel.
// - Channel-pair power-down leaves the converter channel running.

module fpd_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic die_offset,
    output logic [1:0] full_off,
    output logic [1:0] quick_off,
    output logic [1:0] preamp_off,
    output logic [1:0] attenuator_amp_off,
    output logic [1:0] quiet_input_option,
    output logic [1:0] low_noise,
    output logic [1:0] low_power,
    output logic [1:0] med_power,
    output logic [15:0] chan_off,
    output logic [15:0] converter_off,
    output logic [15:0] cw_path_config
);

    ////////////////////////////////////////////////////////////////////////
    fpd_pkg::fpd_state_s s_r;
    fpd_pkg::fpd_state_s s_nxt;
    fpd_pkg::fpd_die_ctl_s die_ctl;

    // Merge write data into a 16-bit register under the two low strobes
    function automatic logic [15:0] fpd_merge(input logic [15:0] old,
        input logic [15:0] wd, input logic [1:0] stb);
        fpd_merge = {stb[1] ? wd[15:8] : old[15:8],
            stb[0] ? wd[7:0] : old[7:0]};
    endfunction : fpd_merge

    function automatic logic fpd_hit(input logic [9:0] a);
        fpd_hit = (a == `FPD_OFS_PDC) || (a == `FPD_OFS_CW);
    endfunction : fpd_hit

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            fpd_pkg::FPD_ST_IDLE: begin
                if (psel && !penable) begin
                    s_nxt.st = fpd_pkg::FPD_ST_SETUP;
                end
            end
            fpd_pkg::FPD_ST_SETUP: begin
                // Access phase takes one cycle; data and error are ready then
                s_nxt.st = fpd_pkg::FPD_ST_ACCESS;
                s_nxt.slverr = !fpd_hit(paddr);
                s_nxt.rdata = '0;
                if (!pwrite && paddr == `FPD_OFS_PDC) begin
                    s_nxt.rdata = {16'h0000, s_r.pdc};
                end else if (!pwrite && paddr == `FPD_OFS_CW) begin
                    s_nxt.rdata = {16'h0000, s_r.cw};
                end
            end
            fpd_pkg::FPD_ST_ACCESS: begin
                // Write takes effect on the edge where pready is seen high
                if (pwrite && paddr == `FPD_OFS_PDC) begin
                    s_nxt.pdc = fpd_merge(s_r.pdc, pwdata[15:0],
                        pstrb[1:0]);
                end else if (pwrite && paddr == `FPD_OFS_CW) begin
                    s_nxt.cw = fpd_merge(s_r.cw, pwdata[15:0],
                        pstrb[1:0]);
                end
                s_nxt.st = (psel && !penable) ? fpd_pkg::FPD_ST_SETUP
                    : fpd_pkg::FPD_ST_IDLE;
            end
            default: begin
                s_nxt.st = fpd_pkg::FPD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.st <= fpd_pkg::FPD_ST_IDLE;
            s_r.pdc <= `FPD_RST_PDC;
            s_r.cw <= `FPD_RST_CW;
            s_r.rdata <= 32'h00000000;
            s_r.slverr <= 1'b0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Held off while frozen, so a write is never acknowledged but dropped
    assign pready = (s_r.st == fpd_pkg::FPD_ST_ACCESS) && clk_en;
    assign prdata = s_r.rdata;
    assign pslverr = pready & s_r.slverr;
    assign cw_path_config = s_r.cw;

    fpd_decode u_decode (
        .pdc(s_r.pdc),
        .die_offset(die_offset),
        .die_ctl(die_ctl),
        .chan_off(chan_off)
    );

    assign full_off = die_ctl.full_off;
    assign quick_off = die_ctl.quick_off;
    assign preamp_off = die_ctl.preamp_off;
    assign attenuator_amp_off = die_ctl.attenuator_amp_off;
    assign quiet_input_option = die_ctl.quiet_input_option;
    assign low_noise = die_ctl.low_noise;
    assign low_power = die_ctl.low_power;
    assign med_power = die_ctl.med_power;
    // Nothing in this block may power down a converter channel
    assign converter_off = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    default clocking fpd_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence fpd_wr_pdc;
        psel && penable && pready && pwrite && paddr == `FPD_OFS_PDC
            && pstrb[1:0] == 2'h3 && clk_en;
    endsequence

    a_deep_both_dies: assert property (
        s_r.pdc[`FPD_B_DEEP] && !die_offset |-> full_off == 2'h3)
        else $error("deep sleep did not reach both dies");

    a_offset_first_die: assert property (
        die_offset |-> !full_off[1] && !quick_off[1] && !preamp_off[1]
            && !attenuator_amp_off[1])
        else $error("die two touched with offset set");

    a_deep_over_quick: assert property (
        s_r.pdc[`FPD_B_DEEP] |-> quick_off == 2'h0)
        else $error("quick sleep active under deep sleep");

    a_no_converter_off: assert property (
        converter_off == 16'h0000)
        else $error("converter channel powered down");

    a_quick_selects: assert property (
        s_r.pdc[`FPD_B_QUICK] && !s_r.pdc[`FPD_B_DEEP]
            |-> quick_off[0] && quick_off[1] == !die_offset)
        else $error("quick sleep die select wrong");

    a_preamp_die: assert property (
        preamp_off == {s_r.pdc[`FPD_B_PREAMP] & !die_offset,
            s_r.pdc[`FPD_B_PREAMP]})
        else $error("preamp power-down mismatch");

    a_attamp_die: assert property (
        attenuator_amp_off[0] == s_r.pdc[`FPD_B_ATTAMP])
        else $error("attenuator power-down mismatch");

    a_profile_onehot: assert property (
        $onehot0({low_noise[0], low_power[0], med_power[0]})
            && (s_r.pdc[`FPD_B_PROF_HI:`FPD_B_PROF_LO] == 2'h0)
            == low_noise[0])
        else $error("profile decode wrong");

    a_quiet_die: assert property (
        quiet_input_option[1] == (s_r.pdc[`FPD_B_QUIET] && !die_offset))
        else $error("quiet input die select wrong");

    a_pair_even_odd: assert property (
        chan_off[15] == s_r.pdc[`FPD_B_PAIR_HI]
            && chan_off[14] == (s_r.pdc[`FPD_B_PAIR_HI] && !die_offset))
        else $error("channel pair decode wrong");

    a_write_readback: assert property (
        fpd_wr_pdc |=> s_r.pdc == $past(pwdata[15:0]))
        else $error("written value not held");

    a_access_one_cycle: assert property (
        psel && !penable && clk_en ##1 clk_en |=> pready)
        else $error("pready late");

endmodule : fpd_regs
`default_nettype wire

// *** dv/fpd_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fpd_cfg.svh"

module fpd_regs_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic die_offset = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] full_off, quick_off, preamp_off, attenuator_amp_off;
    logic [1:0] quiet_input_option, low_noise, low_power, med_power;
    logic [15:0] chan_off, converter_off, cw_path_config;
    logic [15:0] die_word;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int samples_checked = 0;
    // Bit 8 kept clear, quiet bit only with profile 00
    logic [15:0] pats [12] = '{16'h8000, 16'hC000, 16'h4000, 16'h2000,
        16'h1000, 16'h0400, 16'h0800, 16'h0C00, 16'h0200, 16'h00FF,
        16'h0081, 16'hF455};

    assign die_word = {full_off, quick_off, preamp_off, attenuator_amp_off,
        quiet_input_option, low_noise, low_power, med_power};

    fpd_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .die_offset(die_offset), .full_off(full_off),
        .quick_off(quick_off), .preamp_off(preamp_off),
        .attenuator_amp_off(attenuator_amp_off),
        .quiet_input_option(quiet_input_option), .low_noise(low_noise),
        .low_power(low_power), .med_power(med_power), .chan_off(chan_off),
        .converter_off(converter_off), .cw_path_config(cw_path_config));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Pready and prdata are sampled before the edge's own updates land
    task automatic apb(input logic wr, input logic [9:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        check("answer in time", 32'h1, {31'h0, n < 50});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    function automatic logic [15:0] exp_die(input logic [15:0] v,
                                            input logic o);
        logic [1:0] s;
        s = o ? 2'h1 : 2'h3;
        return {v[15] ? s : 2'h0, (v[14] && !v[15]) ? s : 2'h0,
            v[13] ? s : 2'h0, v[12] ? s : 2'h0, v[9] ? s : 2'h0,
            (v[11:10] == 2'h0) ? s : 2'h0, (v[11:10] == 2'h1) ? s : 2'h0,
            (v[11:10] == 2'h2) ? s : 2'h0};
    endfunction : exp_die

    function automatic logic [15:0] exp_chan(input logic [15:0] v,
                                             input logic o);
        logic [15:0] c;
        for (int k = 0; k < 8; k++) begin
            c[2*k] = v[k] & !o;
            c[2*k+1] = v[k];
        end
        return c;
    endfunction : exp_chan

    task automatic check_out(input logic [15:0] v, input logic o);
        check("die controls", {16'h0, exp_die(v, o)}, {16'h0, die_word});
        check("channel off", {16'h0, exp_chan(v, o)}, {16'h0, chan_off});
        check("converter off", 32'h0, {16'h0, converter_off});
    endtask : check_out

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2000) @(posedge pclk);
        err_count++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `FPD_OFS_PDC, 32'h0, 4'hF);
        check("pdc reset", 32'h0, rd);
        apb(1'b0, `FPD_OFS_CW, 32'h0, 4'hF);
        check("cw reset", 32'h0, rd);
        check_out(16'h0000, 1'b0);
        for (int o = 0; o < 2; o++) begin
            die_offset <= o[0];
            foreach (pats[i]) begin
                apb(1'b1, `FPD_OFS_PDC, {16'h0, pats[i]}, 4'hF);
                apb(1'b0, `FPD_OFS_PDC, 32'h0, 4'hF);
                check("pdc readback", {16'h0, pats[i]}, rd);
                check_out(pats[i], o[0]);
            end
        end
        apb(1'b1, `FPD_OFS_CW, 32'hFFFF_7F7F, 4'hF);
        apb(1'b0, `FPD_OFS_CW, 32'h0, 4'hF);
        check("cw readback", 32'h0000_7F7F, rd);
        check("cw output", 32'h7F7F, {16'h0, cw_path_config});
        // Byte strobes: only the enabled byte may change
        apb(1'b1, `FPD_OFS_PDC, 32'h0000_A5A5, 4'h1);
        apb(1'b0, `FPD_OFS_PDC, 32'h0, 4'hF);
        check("low byte write", 32'h0000_F4A5, rd);
        apb(1'b1, `FPD_OFS_PDC, 32'h0000_2A00, 4'h2);
        apb(1'b0, `FPD_OFS_PDC, 32'h0, 4'hF);
        check("high byte write", 32'h0000_2AA5, rd);
        apb(1'b1, 10'h3FC, 32'h0000_FFFF, 4'hF);
        check("unmapped write err", 32'h1, {31'h0, er});
        apb(1'b0, 10'h3FC, 32'h0, 4'hF);
        check("unmapped read err", 32'h1, {31'h0, er});
        check("unmapped read data", 32'h0, rd);
        apb(1'b0, `FPD_OFS_PDC, 32'h0, 4'hF);
        check("pdc untouched", 32'h0000_2AA5, rd);
        // Stall in mid-transfer: the write must still land once
        fork
            apb(1'b1, `FPD_OFS_CW, 32'h0000_1234, 4'hF);
            begin
                @(posedge pclk);
                clk_en <= 1'b0;
                repeat (4) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        apb(1'b0, `FPD_OFS_CW, 32'h0, 4'hF);
        check("stalled write", 32'h0000_1234, rd);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `FPD_OFS_PDC, 32'h0, 4'hF);
        check("pdc second reset", 32'h0, rd);
        apb(1'b0, `FPD_OFS_CW, 32'h0, 4'hF);
        check("cw second reset", 32'h0, rd);
        conclude();
    end
endmodule : fpd_regs_tb
`default_nettype wire
